/* File: logic/fsk_modem_config_timing.sv */
// fsk_modem_config_timing: control register decode, tone plan, watchdog, reset,
// transmit time-out, carrier qualification and master clock output
// assumes a classic Wishbone master on clock; pins are asynchronous to clock
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - refresh pulses 125 ns wide; no refresh for 1.5 s trips the watchdog
// - continuous transmission limited to 1 s or 3 s, chosen by control bits 7-8
// - after time-out transmit stays off 125 ms; clears within 20 us of direction high
// - carrier qualification time 500 us, 1, 3 or 5 ms from bits 9-10
// - master clock output is clock/2, clock/4 or off from bits 15-16
// - bits 3-4 pick 600, 1200, 2400 or 4800 baud with matching bit times
// - eight carrier channels, 132.5 kHz after reset
// - one channel at a time, changeable while running
// - channel choice retunes transmit and receive filters together
// - tone spacing is deviation 0.5 or 1 times baud; reset gives 1200 Hz
// - logic zero sent at carrier plus half the spacing
module fsk_modem_config_timing
  import modem_cfg_pkg::*;
#(
  parameter int unsigned WD_CYC = modem_cfg_pkg::WD_TIMEOUT_CYC,
  parameter int unsigned RST_CYC = modem_cfg_pkg::RST_HOLD_CYC,
  parameter int unsigned TO1_CYC = modem_cfg_pkg::TO_SHORT_CYC,
  parameter int unsigned TO3_CYC = modem_cfg_pkg::TO_LONG_CYC,
  parameter int unsigned OFF_CYC = modem_cfg_pkg::TO_OFF_CYC,
  parameter int unsigned CD0_CYC = modem_cfg_pkg::CD_US[0] * modem_cfg_pkg::CYC_PER_US,
  parameter int unsigned CD1_CYC = modem_cfg_pkg::CD_US[1] * modem_cfg_pkg::CYC_PER_US,
  parameter int unsigned CD2_CYC = modem_cfg_pkg::CD_US[2] * modem_cfg_pkg::CYC_PER_US,
  parameter int unsigned CD3_CYC = modem_cfg_pkg::CD_US[3] * modem_cfg_pkg::CYC_PER_US
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // host pins
  input wire logic transfer_direction,
  input wire logic watchdog_refresh,
  output logic reset_out,
  output logic mclk_out,
  // modem core
  input wire logic carrier_raw,
  output logic carrier_detect,
  output logic tx_enable,
  output logic timeout_flag,
  output modem_cfg_pkg::tone_t tone,
  // interrupt
  output logic irq
);
  import modem_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic dir_s, refresh_s, carrier_s;

  // direction idles high; a low reset level would fake a transmit request after reset
  pin_sync #(.W(3), .RST_LEVEL(3'b100)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin({transfer_direction, watchdog_refresh, carrier_raw}),
    .level({dir_s, refresh_s, carrier_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus
  ctrl_t ctrl, next_ctrl;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [IRQ_W-1:0] events;
  logic [31:0] next_dat;
  logic next_ack, next_irq, bus_req;
  tone_t next_tone;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign bus_req = cyc_i && stb_i && !ack_o;

  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_dat = 32'h0000_0000;
    next_ack = bus_req;
    // a write lands on the edge at which the master sees ack, when the cycle completes
    if (cyc_i && stb_i && we_i && ack_o) begin
      case (adr_i)
        ADDR_CTRL: next_ctrl = 17'(merge({15'h0000, ctrl}, dat_i, sel_i)
                                   & {15'h0000, CTRL_WMASK});
        ADDR_IRQ_MASK: next_irq_mask = 3'(merge({29'h0000_0000, irq_mask}, dat_i, sel_i)
                                          & {29'h0000_0000, 3'h7});
        ADDR_IRQ_STAT: if (sel_i[0]) next_irq_stat = irq_stat & ~dat_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clearing write in the same cycle
    next_irq_stat = next_irq_stat | events;
    if (bus_req && !we_i) begin
      case (adr_i)
        ADDR_CTRL: next_dat = {15'h0000, ctrl};
        ADDR_STATE: next_dat = {28'h000_0000, reset_out, carrier_detect, timeout_flag,
                                tx_enable};
        ADDR_SPACE: next_dat = {14'h0000, tone.space_hz};
        ADDR_MARK: next_dat = {14'h0000, tone.mark_hz};
        ADDR_RATE: next_dat = {16'(BIT_TIME_US[ctrl.baud_sel]),
                               16'(BAUD_RATE[ctrl.baud_sel])};
        ADDR_IRQ_STAT: next_dat = {29'h0000_0000, irq_stat};
        ADDR_IRQ_MASK: next_dat = {29'h0000_0000, irq_mask};
        ADDR_DELTA: next_dat = {14'h0000, tone.delta_hz};
        default: next_dat = 32'h0000_0000;
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      dat_o <= 32'h0000_0000;
      ack_o <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      dat_o <= next_dat;
      ack_o <= next_ack;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tone plan: one channel feeds both filters, so they can never disagree
  always_comb begin
    logic [17:0] baud, half;
    baud = 18'(BAUD_RATE[ctrl.baud_sel]);
    half = 18'h0_0000;
    next_tone.chan = ctrl.chan;
    next_tone.carrier_hz = 18'(CARRIER_HZ[ctrl.chan]);
    // 600 baud is forced to full deviation in case the host breaks its side
    if (ctrl.dev_full || ctrl.baud_sel == BAUD_600) begin
      next_tone.delta_hz = baud;
    end else begin
      next_tone.delta_hz = baud >> 1;
    end
    half = next_tone.delta_hz >> 1;
    next_tone.space_hz = next_tone.carrier_hz + half;
    next_tone.mark_hz = next_tone.carrier_hz - half;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tone <= '0;
    end else begin
      tone <= next_tone;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog and reset output
  logic [31:0] wd_cnt, next_wd_cnt, rst_cnt, next_rst_cnt;
  logic [7:0] pulse_cnt, next_pulse_cnt;
  logic next_reset_out, refresh_ok, wd_trip;

  always_comb begin
    // a refresh counts once the pin has stayed high for the minimum width
    next_pulse_cnt = refresh_s ? ((pulse_cnt == 8'(WD_PULSE_CYC)) ? pulse_cnt
                                  : pulse_cnt + 8'h01) : 8'h00;
    refresh_ok = (pulse_cnt == 8'(WD_PULSE_CYC - 1)) && refresh_s;
    wd_trip = !reset_out && (wd_cnt == 32'(WD_CYC - 1)) && !refresh_ok;
    next_wd_cnt = (reset_out || refresh_ok || wd_trip) ? 32'h0000_0000 : wd_cnt + 32'h1;
    next_reset_out = reset_out;
    next_rst_cnt = 32'h0000_0000;
    if (wd_trip) begin
      next_reset_out = 1'b1;
    end else if (reset_out) begin
      next_rst_cnt = rst_cnt + 32'h1;
      if (rst_cnt == 32'(RST_CYC - 1)) begin
        next_reset_out = 1'b0;
        next_rst_cnt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_cnt <= 8'h00;
      wd_cnt <= 32'h0000_0000;
      rst_cnt <= 32'h0000_0000;
      reset_out <= 1'b1;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      wd_cnt <= next_wd_cnt;
      rst_cnt <= next_rst_cnt;
      reset_out <= next_reset_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit time-out; direction low means the host is transmitting
  to_state_t to_state, next_to_state;
  logic [31:0] to_cnt, next_to_cnt, to_limit;
  logic tx_req, next_tx_enable, to_fire;

  assign tx_req = !dir_s;

  always_comb begin
    to_limit = (ctrl.to_sel == TO_1S) ? 32'(TO1_CYC) : 32'(TO3_CYC);
    next_to_state = to_state;
    next_to_cnt = to_cnt;
    to_fire = 1'b0;
    case (to_state)
      TO_IDLE: begin
        next_to_cnt = 32'h0000_0000;
        if (tx_req && ctrl.to_sel != TO_OFF) begin
          next_to_state = TO_RUN;
        end
      end
      TO_RUN: begin
        next_to_cnt = to_cnt + 32'h1;
        if (!tx_req || ctrl.to_sel == TO_OFF) begin
          next_to_state = TO_IDLE;
        end else if (to_cnt >= to_limit - 32'h1) begin
          next_to_state = TO_HOLD;
          next_to_cnt = 32'h0000_0000;
          to_fire = 1'b1;
        end
      end
      TO_HOLD: begin
        next_to_cnt = to_cnt + 32'h1;
        if (to_cnt == 32'(OFF_CYC - 1)) begin
          next_to_state = TO_WAIT;
        end
      end
      TO_WAIT: begin
        // the flag drops on the next edge after direction is seen high
        if (!tx_req) begin
          next_to_state = TO_IDLE;
        end
      end
      default: next_to_state = TO_IDLE;
    endcase
    next_tx_enable = tx_req && (next_to_state == TO_IDLE || next_to_state == TO_RUN);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      to_state <= TO_IDLE;
      to_cnt <= 32'h0000_0000;
      tx_enable <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      to_state <= next_to_state;
      to_cnt <= next_to_cnt;
      tx_enable <= next_tx_enable;
      timeout_flag <= (next_to_state == TO_HOLD || next_to_state == TO_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier qualification: a dropout restarts the wait
  logic [31:0] cd_cnt, next_cd_cnt, cd_limit;
  logic next_carrier_detect;

  always_comb begin
    case (ctrl.cd_sel)
      2'h0: cd_limit = 32'(CD0_CYC);
      2'h1: cd_limit = 32'(CD1_CYC);
      2'h2: cd_limit = 32'(CD2_CYC);
      default: cd_limit = 32'(CD3_CYC);
    endcase
    next_cd_cnt = 32'h0000_0000;
    next_carrier_detect = 1'b0;
    if (carrier_s) begin
      next_cd_cnt = (cd_cnt >= cd_limit) ? cd_cnt : cd_cnt + 32'h1;
      next_carrier_detect = (next_cd_cnt >= cd_limit);
    end
    events = '0;
    events[IRQ_WD] = wd_trip;
    events[IRQ_TO] = to_fire;
    events[IRQ_CD] = next_carrier_detect && !carrier_detect;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cd_cnt <= 32'h0000_0000;
      carrier_detect <= 1'b0;
    end else begin
      cd_cnt <= next_cd_cnt;
      carrier_detect <= next_carrier_detect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock output, registered so the pin never glitches
  logic [1:0] div, next_div;
  logic next_mclk;

  always_comb begin
    next_div = div + 2'h1;
    case (ctrl.mclk_sel)
      MCLK_DIV2: next_mclk = next_div[0];
      MCLK_DIV4: next_mclk = next_div[1];
      default: next_mclk = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div <= 2'h0;
      mclk_out <= 1'b0;
    end else begin
      div <= next_div;
      mclk_out <= next_mclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_wd_trip;
    @(posedge clock) disable iff (rst)
      (!reset_out && wd_cnt == 32'(WD_CYC - 1) && !refresh_ok) |=> reset_out && irq_stat[IRQ_WD];
  endproperty
  a_wd_trip: assert property (p_wd_trip) else $error("watchdog did not trip");

  property p_rst_hold;
    @(posedge clock) disable iff (rst)
      $fell(reset_out) |-> $past(rst_cnt) == 32'(RST_CYC - 1);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset released early");

  property p_to_fire;
    @(posedge clock) disable iff (rst)
      (to_state == TO_RUN && tx_req && ctrl.to_sel != TO_OFF && to_cnt == to_limit - 32'h1)
      |=> timeout_flag && !tx_enable;
  endproperty
  a_to_fire: assert property (p_to_fire) else $error("time-out missed");

  property p_to_off;
    @(posedge clock) disable iff (rst)
      (to_state == TO_HOLD && to_cnt < 32'(OFF_CYC - 1)) |=> !tx_enable && timeout_flag;
  endproperty
  a_to_off: assert property (p_to_off) else $error("transmit reopened early");

  property p_to_clear;
    @(posedge clock) disable iff (rst)
      (to_state == TO_WAIT && $rose(dir_s)) |-> ##[1:2] !timeout_flag;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("time-out not cleared");

  property p_cd;
    @(posedge clock) disable iff (rst)
      $rose(carrier_detect) |-> $past(carrier_s) && $past(cd_cnt) >= cd_limit - 32'h1;
  endproperty
  a_cd: assert property (p_cd) else $error("carrier qualified too soon");

  property p_mclk2;
    @(posedge clock) disable iff (rst)
      (ctrl.mclk_sel == MCLK_DIV2) [*3] |-> mclk_out != $past(mclk_out);
  endproperty
  a_mclk2: assert property (p_mclk2) else $error("mclk not toggling");

  property p_tone;
    @(posedge clock) disable iff (rst)
      ##1 (tone.space_hz - tone.mark_hz == tone.delta_hz - (tone.delta_hz & 18'h0_0001))
      && (tone.space_hz + tone.mark_hz == {tone.carrier_hz[16:0], 1'b0});
  endproperty
  a_tone: assert property (p_tone) else $error("tones not symmetric");

  property p_dev600;
    @(posedge clock) disable iff (rst)
      (ctrl.baud_sel == BAUD_600) |=> tone.delta_hz == 18'(BAUD_RATE[0]);
  endproperty
  a_dev600: assert property (p_dev600) else $error("600 baud deviation wrong");

  property p_chan;
    @(posedge clock) disable iff (rst)
      1'b1 ##1 1'b1 |=> tone.chan == $past(ctrl.chan) &&
               tone.carrier_hz == 18'(CARRIER_HZ[$past(ctrl.chan)]);
  endproperty
  a_chan: assert property (p_chan) else $error("filters not retuned");

  c_wd: cover property (@(posedge clock) disable iff (rst) $rose(reset_out));
  c_to: cover property (@(posedge clock) disable iff (rst) $fell(timeout_flag));
  c_cd: cover property (@(posedge clock) disable iff (rst) $rose(carrier_detect));
  c_irq: cover property (@(posedge clock) disable iff (rst) $rose(irq));
endmodule
`default_nettype wire

/* File: logic/pin_sync.sv */
// pin_sync: two-flop synchronisers for asynchronous pin inputs
// assumes each bit is an independent level; no bus coherence is given
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1,
  // reset level per bit: set it to the idle level of the pin so reset leaves no false edge
  parameter logic [W-1:0] RST_LEVEL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          meta[i] <= RST_LEVEL[i];
          level[i] <= RST_LEVEL[i];
        end else begin
          meta[i] <= pin[i];
          level[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: pkg/modem_cfg_pkg.sv */
// modem_cfg_pkg: constants, register map and carrier types of the modem configuration block
// assumes a 100 MHz core clock and a classic Wishbone slave with byte addresses
package modem_cfg_pkg;

  // clock and derived cycle counts
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;
  localparam int unsigned WD_PULSE_NS = 125;
  localparam int unsigned WD_PULSE_CYC = (WD_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WD_TIMEOUT_MS = 1500;
  localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned RST_HOLD_MS = 50;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CYC_PER_MS;
  localparam int unsigned TO_SHORT_MS = 1000;
  localparam int unsigned TO_SHORT_CYC = TO_SHORT_MS * CYC_PER_MS;
  localparam int unsigned TO_LONG_MS = 3000;
  localparam int unsigned TO_LONG_CYC = TO_LONG_MS * CYC_PER_MS;
  localparam int unsigned TO_OFF_MS = 125;
  localparam int unsigned TO_OFF_CYC = TO_OFF_MS * CYC_PER_MS;
  localparam int unsigned CD_US [4] = '{500, 1000, 3000, 5000};

  // rate and channel tables, indexed by the control fields
  localparam int unsigned BAUD_RATE [4] = '{600, 1200, 2400, 4800};
  localparam int unsigned BIT_TIME_US [4] = '{1667, 833, 417, 208};
  localparam int unsigned CARRIER_HZ [8] =
    '{60000, 66000, 72000, 76000, 82050, 86000, 110000, 132500};

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_SPACE = 8'h08;
  localparam logic [7:0] ADDR_MARK = 8'h0c;
  localparam logic [7:0] ADDR_RATE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_DELTA = 8'h1c;

  // control register: chan 7, 2400 baud, deviation 0.5, 1 s time-out, mclk /2
  localparam logic [16:0] CTRL_RESET = 17'h0_0097;
  localparam logic [16:0] CTRL_WMASK = 17'h1_87bf;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_WD = 0;
  localparam int unsigned IRQ_TO = 1;
  localparam int unsigned IRQ_CD = 2;

  // field encodings
  localparam logic [1:0] TO_OFF = 2'h0;
  localparam logic [1:0] TO_1S = 2'h1;
  localparam logic [1:0] MCLK_DIV2 = 2'h0;
  localparam logic [1:0] MCLK_DIV4 = 2'h1;
  localparam logic [1:0] BAUD_600 = 2'h0;

  typedef struct packed {
    logic [1:0] mclk_sel;
    logic [3:0] rsv_hi;
    logic [1:0] cd_sel;
    logic [1:0] to_sel;
    logic rsv6;
    logic dev_full;
    logic [1:0] baud_sel;
    logic [2:0] chan;
  } ctrl_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [17:0] carrier_hz;
    logic [17:0] space_hz;
    logic [17:0] mark_hz;
    logic [17:0] delta_hz;
  } tone_t;

  typedef enum {TO_IDLE, TO_RUN, TO_HOLD, TO_WAIT} to_state_t;

endpackage

/* File: verif/fsk_modem_config_timing_tb.sv */
// fsk_modem_config_timing_tb: self-checking bench with a host pin model
// assumes shortened timing parameters; expectations come from the package tables
`timescale 1ns/100ps
`default_nettype none
module fsk_modem_config_timing_tb;
  import modem_cfg_pkg::*;
  localparam int WD = 2000, RH = 100, T1 = 500, T3 = 1500, OFF = 200;
  localparam int CDC [4] = '{20, 40, 60, 80};
  localparam int TL [3] = '{0, T1, T3};
  localparam int MC [4] = '{40, 20, 0, 0};
  logic clock = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic refresh_on = 1, tx_req = 0, carrier_raw = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, q;
  logic ack_o, wd_pin, dir_pin, reset_out, mclk_out, carrier_detect;
  logic tx_enable, timeout_flag, irq, pv;
  tone_t tone;
  int fails = 0, n_checks = 0, n;
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  fsk_modem_config_timing #(.WD_CYC(WD), .RST_CYC(RH), .TO1_CYC(T1), .TO3_CYC(T3),
    .OFF_CYC(OFF), .CD0_CYC(20), .CD1_CYC(40), .CD2_CYC(60), .CD3_CYC(80)) u_dut (
    .clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .transfer_direction(dir_pin), .watchdog_refresh(wd_pin), .reset_out(reset_out),
    .mclk_out(mclk_out), .carrier_raw(carrier_raw), .carrier_detect(carrier_detect),
    .tx_enable(tx_enable), .timeout_flag(timeout_flag), .tone(tone), .irq(irq));
  host_model u_host (.clock(clock), .rst(rst), .refresh_on(refresh_on), .tx_req(tx_req),
    .watchdog_refresh(wd_pin), .transfer_direction(dir_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a count inside its window is reported as itself, outside against the low end
  task automatic check_in(input int v, input int lo, input int hi);
    check(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask
  // classic cycle: hold everything until ack is seen, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clock);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) begin
      fails++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    check(q, e);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return reset_out;
      1: return timeout_flag;
      2: return carrier_detect;
      default: return tx_enable;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v) begin
      @(posedge clock);
      n++;
      if (n > lim) begin
        fails++;
        close_out();
      end
    end
  endtask
  function automatic logic [31:0] mk(int ch, int bd, int dv, int to, int cd, int mc);
    return 32'(ch) | 32'(bd) << 3 | 32'(dv) << 5 | 32'(to) << 7 | 32'(cd) << 9 | 32'(mc) << 15;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int ch, bd, dv, dl, x, d;
    x = $urandom(47863);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    wait_for(0, 1'b0, RH + 10);
    check_in(n, RH - 2, RH + 3);
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    rd(ADDR_DELTA, BAUD_RATE[2] / 2);
    rd(ADDR_SPACE, CARRIER_HZ[7] + BAUD_RATE[2] / 4);
    // every channel at every rate, deviation picked at random above 600 baud, full at 600
    for (int i = 0; i < 32; i++) begin
      ch = i % 8;
      bd = i / 8;
      dv = (bd == 0) ? 1 : $urandom % 2;
      wr(ADDR_CTRL, mk(ch, bd, dv, 1, 0, 0));
      dl = dv ? BAUD_RATE[bd] : BAUD_RATE[bd] / 2;
      repeat (2) @(posedge clock);
      rd(ADDR_SPACE, CARRIER_HZ[ch] + dl / 2);
      rd(ADDR_MARK, CARRIER_HZ[ch] - dl / 2);
      rd(ADDR_DELTA, dl);
      rd(ADDR_RATE, BIT_TIME_US[bd] << 16 | BAUD_RATE[bd]);
      check(32'(tone.chan), ch);
      check(32'(tone.mark_hz), CARRIER_HZ[ch] - dl / 2);
    end
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, mk(7, 2, 0, 1, 0, m));
      repeat (3) @(posedge clock);
      x = 0;
      pv = mclk_out;
      for (int c = 0; c < 40; c++) begin
        @(posedge clock);
        x += (mclk_out !== pv);
        pv = mclk_out;
      end
      check_in(x, MC[m] - 1, MC[m] + 1);
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, mk(7, 2, 0, 1, c, 0));
      carrier_raw <= 1'b1;
      wait_for(2, 1'b1, CDC[c] + 10);
      check_in(n, CDC[c], CDC[c] + 5);
      carrier_raw <= 1'b0;
      wait_for(2, 1'b0, 8);
    end
    // direction lifted inside the off time once, after it once
    for (int t = 0; t < 3; t++) begin
      wr(ADDR_CTRL, mk(7, 2, 0, t, 0, 0));
      tx_req <= 1'b1;
      wait_for(3, 1'b1, 10);
      if (t == 0) begin
        repeat (T3 + 100) @(posedge clock);
        check(timeout_flag, 1'b0);
        rd(ADDR_STATE, 32'h0000_0001);
      end else begin
        wait_for(1, 1'b1, T3 + 10);
        check_in(n, TL[t] - 2, TL[t] + 3);
        d = (t == 1) ? OFF / 2 : OFF + 50;
        repeat (d) @(posedge clock);
        check(tx_enable, 1'b0);
        tx_req <= 1'b0;
        wait_for(1, 1'b0, OFF + 20);
        check_in(n + d, (d > OFF) ? d : OFF, ((d > OFF) ? d : OFF) + 8);
      end
      tx_req <= 1'b0;
      repeat (5) @(posedge clock);
    end
    rd(ADDR_IRQ_STAT, 32'h0000_0006);
    check(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clock);
    check(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    repeat (3 * WD / 2) @(posedge clock);
    check(reset_out, 1'b0);
    refresh_on <= 1'b0;
    wait_for(0, 1'b1, WD + 20);
    check_in(n, WD - 830, WD + 20);
    refresh_on <= 1'b1;
    wait_for(0, 1'b0, RH + 10);
    check_in(n, RH - 2, RH + 3);
    rd(ADDR_IRQ_STAT, 32'h0000_0005);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clock);
    check(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(ADDR_SPACE, 32'hffff_ffff);
    rd(ADDR_SPACE, CARRIER_HZ[7] + BAUD_RATE[2] / 4);
    close_out();
  end
endmodule
`default_nettype wire

/* File: verif/host_model.sv */
// host_model: host side of the pins, watchdog refresh and transmit request
// assumes the bench drives refresh_on and tx_req just after rising clock edges
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // commands from the bench
  input wire logic refresh_on,
  input wire logic tx_req,
  // pins
  output logic watchdog_refresh,
  output logic transfer_direction
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////////
  // 20 cycle pulses every 800 cycles: wide and frequent enough, never back to back
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      watchdog_refresh <= 1'b0;
    end else begin
      cnt <= (cnt == 799) ? 0 : cnt + 1;
      watchdog_refresh <= refresh_on && cnt < 20;
    end
  end
  // low asks to send; a low to high step is what clears a time-out
  assign transfer_direction = !tx_req;
endmodule
`default_nettype wire
